// *** rtl/ric_pkg.sv ***
// Constants, register map and types for reel inertia compensation
package ric_pkg;

  // ==========================================================
  // Clock and ramp timing
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned DS_PER_S     = 10;   // Times held in 0.1 s
  localparam int unsigned STEPS_FULL   = 1000; // 100 % in 0.1 % steps
  localparam int unsigned CYC_PER_STEP = CLK_HZ / DS_PER_S / STEPS_FULL;

  // ==========================================================
  // Register word indices, byte address is index times four
  localparam int unsigned REG_CTRL     = 0;
  localparam int unsigned REG_MOTOR_J  = 1;
  localparam int unsigned REG_REEL_J   = 2;
  localparam int unsigned REG_M1_ME    = 3;
  localparam int unsigned REG_M2_ME    = 4;
  localparam int unsigned REG_REEL_ME  = 5;
  localparam int unsigned REG_CUSHION  = 6;
  localparam int unsigned REG_ACC_SC   = 7;
  localparam int unsigned REG_DEC_SC   = 8;
  localparam int unsigned REG_T1       = 9;
  localparam int unsigned REG_T2       = 10;
  localparam int unsigned REG_GEAR     = 11;
  localparam int unsigned REG_RATED    = 12;
  localparam int unsigned REG_LINE_SPD = 13;
  localparam int unsigned REG_ASSIGN0  = 14;
  localparam int unsigned NCFG         = 17;
  localparam int unsigned REG_STATUS   = 17;

  // ==========================================================
  // Field positions
  localparam int unsigned F_LO        = 0;
  localparam int unsigned F_HI        = 16;
  localparam int unsigned CTRL_UNWIND = 0;
  localparam int unsigned CTRL_SCURVE = 1;

  // ==========================================================
  // Codes, limits and scaling
  localparam logic [15:0] SENT        = 16'h270f; // 9999
  localparam logic [7:0]  FN_ACCEL    = 8'h6f;    // 111
  localparam logic [7:0]  FN_DECEL    = 8'h70;    // 112
  localparam logic [7:0]  FN_SECOND   = 8'h71;    // 113
  localparam logic [7:0]  FN_INHIBIT  = 8'h7a;    // 122
  localparam logic [15:0] MIN_DIAM_MM = 16'h0009;
  localparam logic [15:0] EXP_NEG_MAX = 16'h0007;
  localparam logic [15:0] EXP_POS_MIN = 16'h0065; // 101
  localparam logic [15:0] EXP_POS_MAX = 16'h0068; // 104
  localparam logic [15:0] EXP_POS_OFS = 16'h0064; // 100
  localparam logic [15:0] J_FRAC      = 16'h0007; // Inertia in 1e-7
  localparam logic [15:0] TORQ_MAX    = 16'h0fa0; // 400.0 %
  localparam int unsigned TORQ_K_X100 = 955;      // 9.55
  localparam int unsigned PI_X1000    = 3142;
  localparam int unsigned TORQ_SCALE  = 10000;
  localparam logic [55:0] DEF_MOTOR_J = 56'h0000_0000_98_9680;

  // ==========================================================
  // Reset values
  localparam logic [15:0] T_RST   = 16'h0096; // 15.0 s
  localparam logic [15:0] SC_RST  = 16'h0001; // 0.1 s
  localparam logic [15:0] ONE     = 16'h0001;
  localparam logic [15:0] VAL_RST = 16'h03e8;

  function automatic logic [31:0] cfg_reset(input int unsigned idx);
    case (idx)
      REG_M1_ME, REG_M2_ME, REG_REEL_ME: cfg_reset = {SENT, SENT};
      REG_ACC_SC, REG_DEC_SC:            cfg_reset = {SC_RST, SC_RST};
      REG_T1, REG_T2:                    cfg_reset = {T_RST, T_RST};
      REG_GEAR:                          cfg_reset = {ONE, ONE};
      REG_RATED, REG_LINE_SPD:           cfg_reset = {16'h0000, VAL_RST};
      default:                           cfg_reset = 32'h0000_0000;
    endcase
  endfunction

  // ==========================================================
  // Torque divider states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_DIV  = 2'b11,
    ST_DONE = 2'b10
  } ric_state_e;

endpackage

// *** rtl/ric_inertia_sel.sv ***
// Inertia selection from direct setting or mantissa and exponent
`timescale 1ns/1ps
module ric_inertia_sel #(
  parameter int unsigned JW        = 56,
  parameter bit          ALLOW_POS = 1'b0
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic [15:0]   setting,
  input  wire logic [15:0]   mant,
  input  wire logic [15:0]   expo,
  input  wire logic [JW-1:0] dflt,
  output logic      [JW-1:0] inertia
);

  // ==========================================================
  // Powers of ten
  function automatic logic [39:0] pow10(input logic [3:0] n);
    case (n)
      4'h0:    pow10 = 40'h1;
      4'h1:    pow10 = 40'ha;
      4'h2:    pow10 = 40'h64;
      4'h3:    pow10 = 40'h3e8;
      4'h4:    pow10 = 40'h2710;
      4'h5:    pow10 = 40'h186a0;
      4'h6:    pow10 = 40'hf4240;
      4'h7:    pow10 = 40'h989680;
      4'h8:    pow10 = 40'h5f5e100;
      4'h9:    pow10 = 40'h3b9aca00;
      4'ha:    pow10 = 40'h2540be400;
      4'hb:    pow10 = 40'h174876e800;
      default: pow10 = 40'h1;
    endcase
  endfunction

  logic [JW-1:0] j_d;
  logic [JW-1:0] j_q;

  // Value in 1e-7 kg m2, invalid codes fall back to default
  always_comb begin
    j_d = dflt;
    if (setting != ric_pkg::SENT) begin
      j_d = JW'(setting) * JW'(pow10(ric_pkg::J_FRAC[3:0]));
    end else if (mant == ric_pkg::SENT || expo == ric_pkg::SENT) begin
      j_d = dflt;
    end else if (expo <= ric_pkg::EXP_NEG_MAX) begin
      j_d = JW'(mant) * JW'(pow10(4'(ric_pkg::J_FRAC - expo)));
    end else if (ALLOW_POS && expo >= ric_pkg::EXP_POS_MIN &&
                 expo <= ric_pkg::EXP_POS_MAX) begin
      j_d = JW'(mant) * JW'(pow10(4'(expo - ric_pkg::EXP_POS_OFS +
                                     ric_pkg::J_FRAC)));
    end
  end

  // Registered result
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      j_q <= '0;
    end else begin
      j_q <= j_d;
    end
  end

  assign inertia = j_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_direct_value : assert property (
    setting != ric_pkg::SENT |=>
      inertia == JW'($past(setting)) * JW'(pow10(4'h7)))
    else $error("direct inertia setting not used");

  chk_sentinel_pair : assert property (
    setting == ric_pkg::SENT && (mant == ric_pkg::SENT ||
      expo == ric_pkg::SENT) |=> inertia == $past(dflt))
    else $error("sentinel pair did not select default");

  chk_exp_zero : assert property (
    setting == ric_pkg::SENT && mant != ric_pkg::SENT && expo == 16'h0
      |=> inertia == JW'($past(mant)) * JW'(40'h989680))
    else $error("exponent zero scaling wrong");

endmodule

// *** rtl/ric_ramp.sv ***
// Slew limiter moving one 0.1 % step per programmed period
`timescale 1ns/1ps
module ric_ramp #(
  parameter int unsigned W            = 16,
  parameter int unsigned CYC_PER_STEP = ric_pkg::CYC_PER_STEP
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         clr,
  input  wire logic [W-1:0] target,
  input  wire logic [15:0]  rise_time,
  input  wire logic [15:0]  fall_time,
  output logic      [W-1:0] value
);

  logic [31:0]  period;
  logic [31:0]  cnt_q;
  logic [W-1:0] val_q;

  // Cycles per step from the rise or fall time
  assign period = 32'(target > val_q ? rise_time : fall_time) *
                  32'(CYC_PER_STEP);

  // Step toward target, clear forces zero at once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      val_q <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      val_q <= '0;
      cnt_q <= '0;
    end else if (val_q == target) begin
      cnt_q <= '0;
    end else if (period == 32'h0) begin
      val_q <= target;
      cnt_q <= '0;
    end else if (cnt_q >= period - 32'h1) begin
      val_q <= (target > val_q) ? val_q + W'(1) : val_q - W'(1);
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign value = val_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_ramp_slew : assert property (
    !clr && period != 32'h0 |=> value == $past(value) ||
      value == $past(value) + W'(1) || value == $past(value) - W'(1))
    else $error("ramp moved more than one step");

  chk_ramp_wait : assert property (
    !clr && period != 32'h0 && cnt_q < period - 32'h1
      |=> value == $past(value))
    else $error("ramp stepped before its period");

  chk_ramp_clear : assert property (
    clr |=> value == '0)
    else $error("ramp not cleared");

endmodule

// *** rtl/ric_top.sv ***
// Top level: register slave, input routing, torque math and ramps
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module ric_top #(
  parameter int unsigned N_TERM       = 12,
  parameter int unsigned CYC_PER_STEP = ric_pkg::CYC_PER_STEP,
  parameter int unsigned JW           = 56
) (
  input  wire logic              CLOCK,
  input  wire logic              NRST,
  input  wire logic [6:0]        AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [31:0]       AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  input  wire logic [N_TERM-1:0] TERM_IN,
  input  wire logic              SECOND_MOTOR_SEL,
  input  wire logic [15:0]       DIAM_MM,
  input  wire logic [JW-1:0]     MATERIAL_INERTIA,
  input  wire logic [15:0]       TORQUE_CMD,
  output logic      [17:0]       TORQUE_OUT
);

  localparam int unsigned DW = 128;
  localparam int unsigned NC = ric_pkg::NCFG;

  // ==========================================================
  // Register slave
  logic [31:0] cfg_q [NC];
  logic [31:0] rdata_q;
  logic [31:0] status;
  logic [4:0]  widx;
  logic        req;
  logic        ack_q;

  assign widx            = AVS_ADDRESS[6:2];
  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign AVS_READDATA    = rdata_q;

  // One wait cycle per access
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Settings write with byte enables
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      for (int unsigned i = 0; i < NC; i++) begin
        cfg_q[i] <= ric_pkg::cfg_reset(i);
      end
    end else if (AVS_WRITE && ack_q && widx < 5'(NC)) begin
      for (int b = 0; b < 4; b++) begin
        if (AVS_BYTEENABLE[b]) begin
          cfg_q[widx][8*b +: 8] <= AVS_WRITEDATA[8*b +: 8];
        end
      end
    end
  end

  // Read data, unmapped words read zero
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 32'h0;
    end else if (AVS_READ && !ack_q) begin
      if (widx < 5'(NC)) begin
        rdata_q <= cfg_q[widx];
      end else if (widx == 5'(ric_pkg::REG_STATUS)) begin
        rdata_q <= status;
      end else begin
        rdata_q <= 32'h0;
      end
    end
  end

  // ==========================================================
  // Setting fields
  logic unwind;
  logic scurve;

  assign unwind = cfg_q[ric_pkg::REG_CTRL][ric_pkg::CTRL_UNWIND];
  assign scurve = cfg_q[ric_pkg::REG_CTRL][ric_pkg::CTRL_SCURVE];

  function automatic logic [15:0] lo(input logic [31:0] w);
    lo = w[ric_pkg::F_LO +: 16];
  endfunction

  function automatic logic [15:0] hi(input logic [31:0] w);
    hi = w[ric_pkg::F_HI +: 16];
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [N_TERM:0] pin_m_q;
  logic [N_TERM:0] pin_s_q;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= {SECOND_MOTOR_SEL, TERM_IN};
      pin_s_q <= pin_m_q;
    end
  end

  // ==========================================================
  // Terminal function routing
  logic [N_TERM-1:0] is_acc;
  logic [N_TERM-1:0] is_dec;
  logic [N_TERM-1:0] is_sec;
  logic [N_TERM-1:0] is_inh;
  logic              acc_on;
  logic              dec_on;
  logic              sec_on;
  logic              inh_on;
  logic              motor2;

  for (genvar g = 0; g < N_TERM; g++) begin : g_term
    logic [7:0] code;
    assign code = cfg_q[ric_pkg::REG_ASSIGN0 + g / 4][8 * (g % 4) +: 8];
    assign is_acc[g] = code == ric_pkg::FN_ACCEL;
    assign is_dec[g] = code == ric_pkg::FN_DECEL;
    assign is_sec[g] = code == ric_pkg::FN_SECOND;
    assign is_inh[g] = code == ric_pkg::FN_INHIBIT;
  end

  assign acc_on = |(pin_s_q[N_TERM-1:0] & is_acc);
  assign dec_on = |(pin_s_q[N_TERM-1:0] & is_dec);
  assign sec_on = |(pin_s_q[N_TERM-1:0] & is_sec);
  assign inh_on = |(pin_s_q[N_TERM-1:0] & is_inh);
  assign motor2 = pin_s_q[N_TERM];

  // Conditions that block compensation
  logic comp_ok;

  assign comp_ok = !(acc_on && dec_on)
                   && !inh_on
                   && DIAM_MM > ric_pkg::MIN_DIAM_MM;

  // ==========================================================
  // Motor and reel inertia
  logic [JW-1:0] j_motor;
  logic [JW-1:0] j_reel;
  logic [31:0]   m_me;

  assign m_me = motor2 ? cfg_q[ric_pkg::REG_M2_ME]
                       : cfg_q[ric_pkg::REG_M1_ME];

  ric_inertia_sel #(.JW(JW), .ALLOW_POS(1'b0)) u_motor_j (
    .clk     (CLOCK),
    .nrst    (NRST),
    .setting (lo(cfg_q[ric_pkg::REG_MOTOR_J])),
    .mant    (lo(m_me)),
    .expo    (hi(m_me)),
    .dflt    (JW'(ric_pkg::DEF_MOTOR_J)),
    .inertia (j_motor)
  );

  // Reel inertia, zero when the setting and the mantissa or exponent are sentinels
  ric_inertia_sel #(.JW(JW), .ALLOW_POS(1'b1)) u_reel_j (
    .clk     (CLOCK),
    .nrst    (NRST),
    .setting (lo(cfg_q[ric_pkg::REG_REEL_J])),
    .mant    (lo(cfg_q[ric_pkg::REG_REEL_ME])),
    .expo    (hi(cfg_q[ric_pkg::REG_REEL_ME])),
    .dflt    ('0),
    .inertia (j_reel)
  );

  // ==========================================================
  // Compensation torque in 0.1 % of rated torque
  logic [15:0]   t_sel;
  logic [15:0]   g_num;
  logic [15:0]   g_den;
  logic [DW-1:0] dvd_d;
  logic [DW-1:0] dvs_d;

  // Time by direction and second time select
  assign t_sel = dec_on ?
    (sec_on ? hi(cfg_q[ric_pkg::REG_T2]) : hi(cfg_q[ric_pkg::REG_T1])) :
    (sec_on ? lo(cfg_q[ric_pkg::REG_T2])
            : lo(cfg_q[ric_pkg::REG_T1]));

  assign g_num = lo(cfg_q[ric_pkg::REG_GEAR]);
  assign g_den = hi(cfg_q[ric_pkg::REG_GEAR]);

  // Reflected inertia times speed over diameter, gear and time
  assign dvd_d = (DW'(j_motor) * DW'(g_den) * DW'(g_den) +
                  (DW'(MATERIAL_INERTIA) + DW'(j_reel)) *
                  DW'(g_num) * DW'(g_num)) *
                 DW'(lo(cfg_q[ric_pkg::REG_LINE_SPD])) *
                 DW'(ric_pkg::TORQ_SCALE);
  assign dvs_d = DW'(g_num) * DW'(g_den) * DW'(DIAM_MM) * DW'(t_sel) *
                 DW'(lo(cfg_q[ric_pkg::REG_RATED])) *
                 DW'(ric_pkg::TORQ_K_X100) *
                 DW'(ric_pkg::PI_X1000);

  ric_pkg::ric_state_e st_q;
  logic [DW-1:0]       quo_q;
  logic [DW-1:0]       rem_q;
  logic [DW-1:0]       dvs_q;
  logic [DW:0]         rem_sh;
  logic [7:0]          bit_q;
  logic [15:0]         comp_q;

  assign rem_sh = {rem_q, quo_q[DW-1]};

  // Bit serial divider, restarts after each result
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      st_q  <= ric_pkg::ST_IDLE;
      quo_q <= '0;
      rem_q <= '0;
      dvs_q <= '0;
      bit_q <= 8'h00;
    end else begin
      case (st_q)
        ric_pkg::ST_IDLE: begin
          st_q <= ric_pkg::ST_LOAD;
        end
        ric_pkg::ST_LOAD: begin
          quo_q <= dvd_d;
          dvs_q <= dvs_d;
          rem_q <= '0;
          bit_q <= 8'(DW - 1);
          st_q  <= ric_pkg::ST_DIV;
        end
        ric_pkg::ST_DIV: begin
          if (rem_sh >= {1'b0, dvs_q}) begin
            rem_q <= DW'(rem_sh - {1'b0, dvs_q});
            quo_q <= {quo_q[DW-2:0], 1'b1};
          end else begin
            rem_q <= rem_sh[DW-1:0];
            quo_q <= {quo_q[DW-2:0], 1'b0};
          end
          if (bit_q == 8'h00) begin
            st_q <= ric_pkg::ST_DONE;
          end else begin
            bit_q <= bit_q - 8'h01;
          end
        end
        ric_pkg::ST_DONE: begin
          st_q <= ric_pkg::ST_LOAD;
        end
        default: begin
          st_q <= ric_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Result with limit, zero divisor saturates
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      comp_q <= 16'h0000;
    end else if (st_q == ric_pkg::ST_DONE) begin
      if (dvs_q == '0 || quo_q > DW'(ric_pkg::TORQ_MAX)) begin
        comp_q <= ric_pkg::TORQ_MAX;
      end else begin
        comp_q <= quo_q[15:0];
      end
    end
  end

  // ==========================================================
  // Ramps for both directions
  logic [15:0] acc_tgt;
  logic [15:0] dec_tgt;
  logic [15:0] acc_rise;
  logic [15:0] acc_fall;
  logic [15:0] dec_rise;
  logic [15:0] dec_fall;
  logic [15:0] acc_mag;
  logic [15:0] dec_mag;
  logic [15:0] cushion;

  assign cushion  = lo(cfg_q[ric_pkg::REG_CUSHION]);
  assign acc_rise = scurve ? lo(cfg_q[ric_pkg::REG_ACC_SC]) : cushion;
  assign acc_fall = scurve ? hi(cfg_q[ric_pkg::REG_ACC_SC]) : cushion;
  assign dec_rise = scurve ? lo(cfg_q[ric_pkg::REG_DEC_SC]) : cushion;
  assign dec_fall = scurve ? hi(cfg_q[ric_pkg::REG_DEC_SC]) : cushion;

  // Target drops to zero when the input turns off
  assign acc_tgt = (comp_ok && acc_on) ? comp_q : 16'h0000;
  assign dec_tgt = (comp_ok && dec_on) ? comp_q : 16'h0000;

  ric_ramp #(.W(16), .CYC_PER_STEP(CYC_PER_STEP)) u_acc_ramp (
    .clk       (CLOCK),
    .nrst      (NRST),
    .clr       (~comp_ok),
    .target    (acc_tgt),
    .rise_time (acc_rise),
    .fall_time (acc_fall),
    .value     (acc_mag)
  );

  ric_ramp #(.W(16), .CYC_PER_STEP(CYC_PER_STEP)) u_dec_ramp (
    .clk       (CLOCK),
    .nrst      (NRST),
    .clr       (~comp_ok),
    .target    (dec_tgt),
    .rise_time (dec_rise),
    .fall_time (dec_fall),
    .value     (dec_mag)
  );

  // ==========================================================
  // Torque output and status
  logic signed [17:0] cmd_x;
  logic signed [17:0] acc_x;
  logic signed [17:0] dec_x;
  logic        [17:0] out_q;

  assign cmd_x = 18'(signed'(TORQUE_CMD));
  assign acc_x = unwind ? -$signed({2'b00, acc_mag})
                        : $signed({2'b00, acc_mag});
  assign dec_x = unwind ? $signed({2'b00, dec_mag})
                        : -$signed({2'b00, dec_mag});

  // Command plus both compensations
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      out_q <= 18'h0;
    end else begin
      out_q <= 18'(cmd_x + acc_x + dec_x);
    end
  end

  assign TORQUE_OUT = out_q;
  assign status     = {comp_q, 11'h0, comp_ok, inh_on, sec_on, dec_on,
                       acc_on};

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  chk_inhibit_clear : assert property (
    inh_on |=> acc_mag == 16'h0 && dec_mag == 16'h0)
    else $error("inhibit left compensation active");

  chk_both_inputs : assert property (
    acc_on && dec_on |=> acc_mag == 16'h0 && dec_mag == 16'h0)
    else $error("both inputs on left compensation active");

  chk_small_diam : assert property (
    DIAM_MM <= ric_pkg::MIN_DIAM_MM
      |=> acc_mag == 16'h0 && dec_mag == 16'h0)
    else $error("small diameter left compensation active");

  chk_idle_pass : assert property (
    acc_mag == 16'h0 && dec_mag == 16'h0
      |=> $signed(TORQUE_OUT) == $past(cmd_x))
    else $error("torque changed with no compensation");

  chk_accel_wind : assert property (
    !unwind && dec_mag == 16'h0 |=> $signed(TORQUE_OUT) ==
      $past(cmd_x) + $signed({2'b00, $past(acc_mag)}))
    else $error("winding accel did not raise torque");

  chk_accel_unwind : assert property (
    unwind && dec_mag == 16'h0 |=> $signed(TORQUE_OUT) ==
      $past(cmd_x) - $signed({2'b00, $past(acc_mag)}))
    else $error("unwinding accel did not lower torque");

  chk_decel_wind : assert property (
    !unwind && acc_mag == 16'h0 |=> $signed(TORQUE_OUT) ==
      $past(cmd_x) - $signed({2'b00, $past(dec_mag)}))
    else $error("winding decel did not lower torque");

  chk_accel_route : assert property (
    $rose(acc_on) && $stable(is_acc)
      |-> $past(|(TERM_IN & is_acc), 2))
    else $error("accel came from an unassigned terminal");

  cov_accel_wind : cover property (!unwind && acc_mag > 16'h0);
  cov_decel_unwind : cover property (unwind && dec_mag > 16'h0);
  cov_scurve_ramp : cover property (scurve && acc_mag != 16'h0);
  cov_div_done : cover property (st_q == ric_pkg::ST_DONE && comp_q != 0);

endmodule

// *** testbench/ric_master_model.sv ***
// Upstream line speed master driving accel and decel flags
`timescale 1ns/1ps
module ric_master_model (
  input  wire logic       clk,
  output logic      [1:0] flags
);
  // ======================================
  // Flags: bit0 accelerating, bit1 decelerating
  initial flags = 2'b00;
  // Flags move just after an edge; the bench may change ramp times mid-ramp
  task automatic drive(input logic [1:0] f);
    @(posedge clk);
    flags <= f;
  endtask
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for reel inertia compensation
`timescale 1ns/1ps
module tb;
  // ======================================
  // Signals
  logic        clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, waitr;
  logic [6:0]  adr = 7'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [9:0]  term = 10'h000;
  logic [1:0]  flg;
  logic [15:0] diam = 16'h0064;
  logic [17:0] tout;
  logic [3:0]  be = 4'hf;
  logic        sel2 = 1'b0;
  logic [55:0] jmat = 56'h0;
  logic [15:0] cmd = 16'h0064;
  int          n_mismatch = 0, n_compared = 0, cyc = 0;
  // Clock of 40 ns period
  always #20 clk = ~clk;
  // Partner and block under test
  ric_master_model u_master (.clk(clk), .flags(flg));
  ric_top #(.CYC_PER_STEP(2)) u_dut (
    .CLOCK(clk), .NRST(nrst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitr),
    .TERM_IN({term, flg}), .SECOND_MOTOR_SEL(sel2), .DIAM_MM(diam),
    .MATERIAL_INERTIA(jmat), .TORQUE_CMD(cmd), .TORQUE_OUT(tout));
  // ======================================
  // Helpers
  task automatic bus(input logic w, input logic [4:0] i,
                     input logic [31:0] d);
    @(posedge clk);
    adr <= {i, 2'b00};
    wd <= d;
    wr <= w;
    rd <= ~w;
    // Hold the request until waitrequest is seen low at a rising edge
    do begin
      @(posedge clk);
    end while (waitr !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_out(input logic [17:0] exp);
    for (int k = 0; k < 600 && tout !== exp; k++) @(negedge clk);
    chk({14'h0, tout}, {14'h0, exp});
  endtask
  task automatic pins(input logic [9:0] t, input logic [15:0] d);
    @(posedge clk);
    term <= t;
    diam <= d;
  endtask
  // ======================================
  // Scenarios
  task automatic t_regs;
    bus(1'b0, 5'd3, 32'h0);
    chk(q, 32'h270f270f);
    bus(1'b0, 5'd20, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 5'd1, 32'h1f4);
    bus(1'b1, 5'd9, 32'h00010001);
    bus(1'b1, 5'd14, 32'h7a71706f);
  endtask
  task automatic t_block;
    u_master.drive(2'b01);
    wait_out(18'h01004);
    u_master.drive(2'b11);
    wait_out(18'h00064);
    u_master.drive(2'b01);
    wait_out(18'h01004);
    pins(10'h002, 16'h0064);
    wait_out(18'h00064);
    pins(10'h000, 16'h0009);
    wait_out(18'h00064);
    pins(10'h000, 16'h000a);
    wait_out(18'h01004);
    u_master.drive(2'b00);
    wait_out(18'h00064);
    u_master.drive(2'b10);
    wait_out(18'h3f0c4);
    u_master.drive(2'b00);
    pins(10'h004, 16'h0064);
    repeat (300) @(negedge clk);
    chk({14'h0, tout}, 32'h64);
  endtask
  task automatic t_unwind;
    bus(1'b1, 5'd0, 32'h1);
    u_master.drive(2'b01);
    wait_out(18'h3f0c4);
    u_master.drive(2'b10);
    wait_out(18'h01004);
    bus(1'b1, 5'd0, 32'h0);
    u_master.drive(2'b01);
  endtask
  task automatic t_inertia;
    bus(1'b1, 5'd1, 32'h270f);
    wait_out(18'h001b1);
    bus(1'b1, 5'd3, 32'h5);
    wait_out(18'h006e6);
    bus(1'b1, 5'd2, 32'h270f);
    bus(1'b1, 5'd5, 32'h1);
    wait_out(18'h00833);
    bus(1'b1, 5'd1, 32'h1);
    bus(1'b1, 5'd5, 32'h00650001);
    wait_out(18'h00eb5);
  endtask
  task automatic t_cushion;
    u_master.drive(2'b00);
    wait_out(18'h00064);
    bus(1'b1, 5'd6, 32'h1);
    u_master.drive(2'b01);
    for (int k = 0; k < 600 && tout === 18'h64; k++) @(negedge clk);
    repeat (200) @(negedge clk);
    chk(32'(tout > 18'hbf && tout < 18'hd1), 32'h1);
  endtask
  // Second time, second motor, byte enables, material and command
  task automatic t_select;
    bus(1'b1, 5'd6, 32'h0);
    pins(10'h005, 16'h0064);
    wait_out(18'h0007c);
    pins(10'h004, 16'h0064);
    bus(1'b1, 5'd1, 32'h270f);
    bus(1'b1, 5'd4, 32'h00010003);
    @(posedge clk);
    sel2 <= 1'b1;
    wait_out(18'h00dcc);
    @(posedge clk);
    be <= 4'h3;
    bus(1'b1, 5'd4, 32'h00070002);
    be <= 4'hf;
    bus(1'b0, 5'd4, 32'h0);
    chk(q, 32'h00010002);
    @(posedge clk);
    jmat <= 56'h98_9680;
    cmd <= 16'hff9c;
    wait_out(18'h00e30);
  endtask
  // S-curve times replace the slow cushion time
  task automatic t_scurve;
    bus(1'b1, 5'd6, 32'h0fff);
    bus(1'b1, 5'd7, 32'h0);
    bus(1'b1, 5'd0, 32'h2);
    u_master.drive(2'b00);
    wait_out(18'h3ff9c);
    u_master.drive(2'b01);
    wait_out(18'h00e30);
  endtask
  // ======================================
  // Verdict and run control
  task automatic final_report;
    $display("Mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      final_report;
    end
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_block;
    t_unwind;
    t_inertia;
    t_cushion;
    t_select;
    t_scurve;
    final_report;
  end
endmodule
